// [logic/exa_alu.sv]
// extended alu: subtract with carry, byte swap, sign extend, test, xor
// assumes an apb master on pclk; operands and status set over apb
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "exa_alu_regs.svh"

module exa_alu (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb request
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    // apb answer
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    import exa_pkg::*;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------

    // all-ones mask of the operand size
    // an unused size code falls back to byte width
    function automatic logic [19:0] size_mask(input exa_size_t sz);
        case (sz)
            EXA_SZ_ADDR: size_mask = 20'hFFFFF;
            EXA_SZ_WORD: size_mask = 20'h0FFFF;
            EXA_SZ_BYTE: size_mask = 20'h000FF;
            default:     size_mask = 20'h000FF;
        endcase
    endfunction

    function automatic logic top_bit(input logic [20:0] v, input exa_size_t sz);
        case (sz)
            EXA_SZ_ADDR: top_bit = v[19];
            EXA_SZ_WORD: top_bit = v[15];
            EXA_SZ_BYTE: top_bit = v[7];
            default:     top_bit = v[7];
        endcase
    endfunction

    // carry out just above the top bit
    function automatic logic carry_out(input logic [20:0] v, input exa_size_t sz);
        case (sz)
            EXA_SZ_ADDR: carry_out = v[20];
            EXA_SZ_WORD: carry_out = v[16];
            EXA_SZ_BYTE: carry_out = v[8];
            default:     carry_out = v[8];
        endcase
    endfunction

    // known register offset
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `EXA_CMD_OFS) || (a == `EXA_SRC_OFS) ||
                    (a == `EXA_DST_OFS) || (a == `EXA_SR_OFS) ||
                    (a == `EXA_RESULT_OFS) || (a == `EXA_INFO_OFS);
    endfunction

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [19:0] src_q;
    logic [31:0] dst_q;
    logic [15:0] sr_q;
    logic [31:0] result_q;
    logic        store_q;
    logic        illegal_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic        setup_ph;
    logic        wr_commit;
    logic        exec_fire;
    exa_cmd_t    cmd;
    exa_flags_t  sr_flags;
    exa_res_t    res;

    // an operation runs at the access edge of the command write; operands,
    // status and command are all taken at that one edge, so a software
    // write to the status word can never meet a flag update in one cycle
    assign setup_ph  = psel & ~penable;
    assign wr_commit = psel & penable & pwrite & ~pslverr_q;
    assign exec_fire = wr_commit & (paddr == `EXA_CMD_OFS);

    // command fields straight off the write data
    assign cmd.op      = exa_op_t'(pwdata[`EXA_CMD_OP_LSB +: 3]);
    assign cmd.size    = exa_size_t'(pwdata[`EXA_CMD_SIZE_LSB +: 2]);
    assign cmd.mem_dst = pwdata[`EXA_CMD_MEM_BIT];

    assign sr_flags.n = sr_q[`EXA_SR_N_BIT];
    assign sr_flags.z = sr_q[`EXA_SR_Z_BIT];
    assign sr_flags.c = sr_q[`EXA_SR_C_BIT];
    assign sr_flags.v = sr_q[`EXA_SR_V_BIT];

    // ------------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------------
    always_comb begin
        logic [19:0] m;
        logic [19:0] s_in;
        logic [19:0] d_in;
        logic [20:0] sum;
        logic [19:0] sized;
        logic [15:0] swapped;
        logic        s_neg;
        logic        d_neg;
        m         = size_mask(cmd.size);
        s_in      = src_q & m;
        d_in      = dst_q[19:0] & m;
        sum       = 21'h000000;
        sized     = 20'h00000;
        swapped   = {dst_q[7:0], dst_q[15:8]};
        s_neg     = top_bit({1'b0, s_in}, cmd.size);
        d_neg     = top_bit({1'b0, d_in}, cmd.size);
        res       = '0;
        res.flags = sr_flags;
        case (cmd.op)
            EXA_OP_SUBC: begin
                // inverted source plus carry plus destination
                sum   = {1'b0, ~src_q & m} + {1'b0, d_in} + {20'h00000, sr_flags.c};
                sized = sum[19:0] & m;
                // sized result clears upper register bits
                res.value     = {12'h000, sized};
                res.store     = 1'b1;
                res.flags_upd = 1'b1;
                res.flags.n   = top_bit({1'b0, sized}, cmd.size);
                res.flags.z   = (sized == 20'h00000);
                // carry out of the top bit
                res.flags.c   = carry_out(sum, cmd.size);
                res.flags.v   = (s_neg != d_neg) &&
                                (top_bit({1'b0, sized}, cmd.size) == s_neg);
            end
            EXA_OP_SWAP: begin
                res.flags_upd = 1'b0;
                // byte size has no swap form: refused, nothing stored
                res.store     = (cmd.size != EXA_SZ_BYTE);
                res.illegal   = (cmd.size == EXA_SZ_BYTE);
                if (!cmd.mem_dst) begin
                    // register swap, upper nibble per size
                    if (cmd.size == EXA_SZ_ADDR) begin
                        res.value = {12'h000, dst_q[19:16], swapped};
                    end else begin
                        res.value = {16'h0000, swapped};
                    end
                end else if (cmd.size == EXA_SZ_ADDR) begin
                    res.value = {12'h000, dst_q[19:16], swapped};
                end else begin
                    res.value = {dst_q[31:16], swapped};
                end
            end
            EXA_OP_SXT: begin
                res.store     = (cmd.size != EXA_SZ_BYTE);
                res.illegal   = (cmd.size == EXA_SZ_BYTE);
                res.flags_upd = (cmd.size != EXA_SZ_BYTE);
                if (!cmd.mem_dst) begin
                    res.value = {12'h000, {12{dst_q[7]}}, dst_q[7:0]};
                end else if (cmd.size == EXA_SZ_ADDR) begin
                    res.value = {12'h000, {12{dst_q[7]}}, dst_q[7:0]};
                end else begin
                    res.value = {dst_q[31:16], {8{dst_q[7]}}, dst_q[7:0]};
                end
                sized = res.value[19:0] & m;
                res.flags.z = (sized == 20'h00000);
                // carry not zero, overflow clear, negative
                res.flags.n = top_bit({1'b0, sized}, cmd.size);
                res.flags.c = (sized != 20'h00000);
                res.flags.v = 1'b0;
            end
            EXA_OP_TEST: begin
                // add all-ones plus one, flags only
                sum   = {1'b0, d_in} + {1'b0, m} + 21'h000001;
                sized = sum[19:0] & m;
                res.value     = {12'h000, sized};
                res.store     = 1'b0;
                res.flags_upd = 1'b1;
                // destination sign and zero, carry set
                res.flags.n   = d_neg;
                res.flags.z   = (d_in == 20'h00000);
                res.flags.c   = 1'b1;
                res.flags.v   = 1'b0;
            end
            EXA_OP_XOR: begin
                sized = s_in ^ d_in;
                // sized result clears upper register bits
                res.value     = {12'h000, sized};
                res.store     = 1'b1;
                res.flags_upd = 1'b1;
                res.flags.n   = top_bit({1'b0, sized}, cmd.size);
                res.flags.z   = (sized == 20'h00000);
                res.flags.c   = (sized != 20'h00000);
                res.flags.v   = s_neg & d_neg;
            end
            default: begin
                res.illegal = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // operand registers
    // ------------------------------------------------------------------

    // source operand, never touched by an operation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q <= 20'h00000;
        end else if (wr_commit && paddr == `EXA_SRC_OFS) begin
            src_q <= pwdata[19:0];
        end
    end

    // destination operand as fetched by the sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dst_q <= `EXA_WORD_RST;
        end else if (wr_commit && paddr == `EXA_DST_OFS) begin
            dst_q <= pwdata;
        end
    end

    // ------------------------------------------------------------------
    // status register
    // ------------------------------------------------------------------

    // mode bits only ever change by a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_q <= `EXA_SR_RST;
        end else if (wr_commit && paddr == `EXA_SR_OFS) begin
            sr_q <= pwdata[15:0] & `EXA_SR_MASK;
        end else if (exec_fire && res.flags_upd) begin
            sr_q[`EXA_SR_N_BIT] <= res.flags.n;
            sr_q[`EXA_SR_Z_BIT] <= res.flags.z;
            sr_q[`EXA_SR_C_BIT] <= res.flags.c;
            sr_q[`EXA_SR_V_BIT] <= res.flags.v;
        end
    end

    // ------------------------------------------------------------------
    // result and outcome
    // ------------------------------------------------------------------

    // result word and store request for the sequencer
    // held until the next command, reads never disturb it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q  <= `EXA_WORD_RST;
            store_q   <= 1'b0;
            illegal_q <= 1'b0;
        end else if (exec_fire) begin
            // test leaves the store request low
            result_q  <= res.value;
            store_q   <= res.store;
            illegal_q <= res.illegal;
        end
    end

    // ------------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------------

    // read data is captured in the setup cycle so that it stands settled
    // through the whole access phase; a write committed at an earlier
    // access edge is already visible to the read that follows it
    // read data and error caught in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup_ph) begin
            pslverr_q <= !is_mapped(paddr) ||
                         (pwrite && (paddr == `EXA_RESULT_OFS ||
                                     paddr == `EXA_INFO_OFS));
            case (paddr)
                `EXA_SRC_OFS:    prdata_q <= {12'h000, src_q};
                `EXA_DST_OFS:    prdata_q <= dst_q;
                `EXA_SR_OFS:     prdata_q <= {16'h0000, sr_q};
                `EXA_RESULT_OFS: prdata_q <= result_q;
                `EXA_INFO_OFS:   prdata_q <= {30'h0, illegal_q, store_q};
                default:         prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // zero wait states: every access phase is answered at once
    // the master still waits on pready, so added wait states stay legal
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q & psel & penable;

endmodule

// [logic/exa_alu_regs.svh]
// register offsets, field positions and reset values of the extended alu
// assumes an 8-bit apb byte address and 32-bit data words
`ifndef EXA_ALU_REGS_SVH
`define EXA_ALU_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define EXA_CMD_OFS      8'h00
`define EXA_SRC_OFS      8'h04
`define EXA_DST_OFS      8'h08
`define EXA_SR_OFS       8'h0C
`define EXA_RESULT_OFS   8'h10
`define EXA_INFO_OFS     8'h14

// ----------------------------------------------------------------------
// command word fields
// ----------------------------------------------------------------------
`define EXA_CMD_OP_LSB   0
`define EXA_CMD_SIZE_LSB 4
`define EXA_CMD_MEM_BIT  8

// ----------------------------------------------------------------------
// status register bit positions
// ----------------------------------------------------------------------
`define EXA_SR_C_BIT     0
`define EXA_SR_Z_BIT     1
`define EXA_SR_N_BIT     2
`define EXA_SR_GIE_BIT   3
`define EXA_SR_CPU_BIT   4
`define EXA_SR_OSC_BIT   5
`define EXA_SR_V_BIT     8
`define EXA_SR_MASK      16'h013F

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define EXA_SR_RST       16'h0000
`define EXA_WORD_RST     32'h0000_0000

`endif

// [logic/exa_pkg.sv]
// types shared by the extended alu datapath
// assumes the register header for offsets and field positions
package exa_pkg;

    // ------------------------------------------------------------------
    // operations and sizes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        EXA_OP_SUBC = 3'b000,
        EXA_OP_SWAP = 3'b001,
        EXA_OP_SXT  = 3'b010,
        EXA_OP_TEST = 3'b011,
        EXA_OP_XOR  = 3'b100
    } exa_op_t;

    typedef enum logic [1:0] {
        EXA_SZ_ADDR = 2'b00,
        EXA_SZ_WORD = 2'b01,
        EXA_SZ_BYTE = 2'b10
    } exa_size_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } exa_flags_t;

    typedef struct packed {
        exa_op_t   op;
        exa_size_t size;
        logic      mem_dst;
    } exa_cmd_t;

    typedef struct packed {
        logic [31:0] value;
        exa_flags_t  flags;
        logic        flags_upd;
        logic        store;
        logic        illegal;
    } exa_res_t;

endpackage

// [dv/exa_alu_asserts.sv]
// checker for the extended alu, watching only its apb ports
// assumes the bind below; operands are snapshot at each command write
`timescale 1ns/100ps
module exa_alu_asserts (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb request
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // apb answer
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    import exa_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // shadow of software writes and command snapshot
    // ------------------------------------------------------------
    logic        wr, rd, res_rd, sr_rd, inf_rd;
    logic [2:0]  op_q, mode_q;
    logic [1:0]  sz_q;
    logic        c_q, c_ok_q, cin_q, cin_ok_q, fresh_q, mem_q;
    logic [19:0] src_q, osrc_q, msk;
    logic [31:0] dst_q, odst_q, exp_sub;
    int          sb;
    assign wr = psel && penable && pready && pwrite;
    assign rd = psel && penable && pready && !pwrite;
    assign res_rd = rd && paddr == 8'h10;
    assign sr_rd = rd && paddr == 8'h0C && fresh_q;
    assign inf_rd = rd && paddr == 8'h14;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {op_q, mode_q, sz_q, c_q, c_ok_q, cin_q, cin_ok_q, fresh_q, mem_q} <= '0;
            {src_q, osrc_q, dst_q, odst_q} <= '0;
        end else if (wr) begin
            case (paddr)
                8'h04: src_q <= pwdata[19:0];
                8'h08: dst_q <= pwdata;
                8'h0C: {c_q, c_ok_q, mode_q, fresh_q} <= {pwdata[0], 1'h1, pwdata[5:3], 1'h0};
                8'h00: begin
                    {op_q, sz_q, mem_q, osrc_q, odst_q} <=
                        {pwdata[2:0], pwdata[5:4], pwdata[8], src_q, dst_q};
                    {cin_q, cin_ok_q, c_ok_q, fresh_q} <= {c_q, c_ok_q, 1'h0, 1'h1};
                end
                default: ;
            endcase
        end
    end
    // size mask, sign position and expected subtract result
    assign msk = (sz_q == 2'h0) ? 20'hFFFFF : (sz_q == 2'h1) ? 20'h0FFFF : 20'h000FF;
    assign sb = (sz_q == 2'h0) ? 19 : (sz_q == 2'h1) ? 15 : 7;
    assign exp_sub = {12'h0, (~osrc_q + odst_q[19:0] + {19'h0, cin_q}) & msk};
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_subc_result: assert property (res_rd && op_q == EXA_OP_SUBC && cin_ok_q
        |-> prdata == exp_sub) else $error("subtract result wrong");
    chk_subc_flags: assert property (sr_rd && op_q == EXA_OP_SUBC && cin_ok_q
        |-> prdata[2] == exp_sub[sb] && prdata[1] == (exp_sub == 32'h0))
        else $error("subtract sign or zero flag wrong");
    chk_swap_addr: assert property (res_rd && op_q == EXA_OP_SWAP && sz_q == 2'h0
        |-> prdata == {12'h0, odst_q[19:16], odst_q[7:0], odst_q[15:8]})
        else $error("address-word swap wrong");
    chk_swap_word_mem: assert property (res_rd && op_q == EXA_OP_SWAP && sz_q == 2'h1
        |-> prdata == {(mem_q ? odst_q[31:16] : 16'h0), odst_q[7:0], odst_q[15:8]})
        else $error("word swap wrong");
    chk_sext_addr: assert property (res_rd && op_q == EXA_OP_SXT && sz_q == 2'h0
        |-> prdata == {12'h0, {12{odst_q[7]}}, odst_q[7:0]}) else $error("sign extend wrong");
    chk_sext_flags: assert property (sr_rd && op_q == EXA_OP_SXT && sz_q != 2'h2
        |-> prdata[0] == !prdata[1] && !prdata[8]) else $error("sign extend flags wrong");
    chk_test_nostore: assert property (inf_rd && op_q == EXA_OP_TEST
        |-> !prdata[0]) else $error("test requested a store");
    chk_test_flags: assert property (sr_rd && op_q == EXA_OP_TEST
        |-> prdata[0] && !prdata[8]) else $error("test carry or overflow wrong");
    chk_xor_result: assert property (res_rd && op_q == EXA_OP_XOR
        |-> prdata == {12'h0, (osrc_q ^ odst_q[19:0]) & msk}) else $error("xor result wrong");
    chk_xor_flags: assert property (sr_rd && op_q == EXA_OP_XOR
        |-> prdata[0] == !prdata[1] && prdata[8] == (osrc_q[sb] && odst_q[sb]))
        else $error("xor carry or overflow wrong");
    chk_mode_keep: assert property (rd && paddr == 8'h0C
        |-> prdata[5:3] == mode_q) else $error("mode bits changed");
    chk_ro_refused: assert property (psel && !penable && pwrite && paddr[7:4] == 4'h1
        |=> pslverr) else $error("read-only write not refused");
    cover property (res_rd && op_q == EXA_OP_SUBC && cin_ok_q);
    cover property (sr_rd && op_q == EXA_OP_XOR && prdata[8]);
    cover property (psel && penable && pslverr);
endmodule

bind exa_alu exa_alu_asserts chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

// [dv/exa_seq_model.sv]
// operand sequencer model: apb master that feeds and collects the alu
// assumes the caller steps one transfer at a time through xfer
`timescale 1ns/100ps
module exa_seq_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    // apb answer
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    import exa_pkg::*;
    // idle bus at time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // one transfer; request held until pready seen high at an edge, giving up after 16 edges
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output logic t);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        t = 1'h1;
        for (int i = 0; i < 16 && t; i++) begin
            @(posedge pclk);
            t = !pready;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        paddr <= ~a; // released lines do not keep the old value
        pwdata <= ~d;
    endtask
endmodule

// [dv/exa_alu_tb.sv]
// self-checking bench for the extended alu over apb
// assumes the sequencer model as master and the bound checker
`timescale 1ns/100ps
module exa_alu_tb;
    import exa_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ev, to;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rv;
    int          error_cnt, cmp_count;
    // 100 mhz clock
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    exa_alu dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    exa_seq_model host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    // ------------------------------------------------------------
    // compare, access and closing tasks
    // ------------------------------------------------------------
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected error flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // a read compares data, every access compares the error flag
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        host.xfer(w, a, d, rv, ev, to);
        if (to) begin
            error_cnt++;
            end_of_test();
        end else begin
            chk1(ev, e);
            if (!w) begin
                chk32(rv, d);
            end
        end
    endtask
    // load operands and status, issue command, read result unless illegal, status, info
    task automatic op(input logic [8:0] cmd, input logic [19:0] s, input logic [31:0] d,
                      input logic [8:0] sr, input logic [31:0] r, input logic [8:0] fx,
                      input logic [1:0] inf);
        acc(1'h1, 8'h04, {12'h0, s}, 1'h0);
        acc(1'h1, 8'h08, d, 1'h0);
        acc(1'h1, 8'h0C, {23'h0, sr}, 1'h0);
        acc(1'h1, 8'h00, {23'h0, cmd}, 1'h0);
        if (!inf[1]) begin
            acc(1'h0, 8'h10, r, 1'h0);
        end
        acc(1'h0, 8'h0C, {23'h0, fx}, 1'h0);
        acc(1'h0, 8'h14, {30'h0, inf}, 1'h0);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        error_cnt = 0;
        cmp_count = 0;
        presetn = 1'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        for (int i = 0; i < 6; i++) begin
            acc(1'h0, 8'(4 * i), 32'h0, 1'h0);
        end
        acc(1'h0, 8'h18, 32'h0, 1'h1);
        acc(1'h1, 8'h10, 32'hFFFFFFFF, 1'h1);
        acc(1'h1, 8'h14, 32'hFFFFFFFF, 1'h1);
        acc(1'h0, 8'h10, 32'h0, 1'h0);
        acc(1'h1, 8'h0C, 32'hFFFFFFFF, 1'h0);
        acc(1'h0, 8'h0C, 32'h0000013F, 1'h0);
        acc(1'h1, 8'h04, 32'hFFFFFFFF, 1'h0);
        acc(1'h0, 8'h04, 32'h000FFFFF, 1'h0);
        op(9'h000, 20'h00001, 32'h00000001, 9'h039, 32'h00000000, 9'h03B, 2'h1);
        op(9'h010, 20'hF0001, 32'h000A8000, 9'h038, 32'h00007FFE, 9'h139, 2'h1);
        op(9'h120, 20'h00080, 32'h0000007F, 9'h039, 32'h000000FF, 9'h13C, 2'h1);
        op(9'h001, 20'h00000, 32'hABC23456, 9'h13F, 32'h00025634, 9'h13F, 2'h1);
        op(9'h011, 20'h00000, 32'h00023456, 9'h13F, 32'h00005634, 9'h13F, 2'h1);
        op(9'h101, 20'h00000, 32'hABC23456, 9'h038, 32'h00025634, 9'h038, 2'h1);
        op(9'h111, 20'h00000, 32'hABC23456, 9'h107, 32'hABC25634, 9'h107, 2'h1);
        op(9'h002, 20'h00000, 32'h00000080, 9'h138, 32'h000FFF80, 9'h03D, 2'h1);
        op(9'h012, 20'h00000, 32'h0000127F, 9'h138, 32'h0000007F, 9'h039, 2'h1);
        op(9'h102, 20'h00000, 32'hFFF00000, 9'h13D, 32'h00000000, 9'h03A, 2'h1);
        op(9'h112, 20'h00000, 32'hABCD12F0, 9'h138, 32'hABCDFFF0, 9'h03D, 2'h1);
        op(9'h003, 20'h00000, 32'h00012345, 9'h138, 32'h00012345, 9'h039, 2'h0);
        op(9'h013, 20'h00000, 32'h00008000, 9'h038, 32'h00008000, 9'h03D, 2'h0);
        op(9'h023, 20'h00000, 32'h00000100, 9'h138, 32'h00000000, 9'h03B, 2'h0);
        op(9'h004, 20'h80001, 32'h00080001, 9'h038, 32'h00000000, 9'h13A, 2'h1);
        op(9'h014, 20'h18000, 32'h00021234, 9'h038, 32'h00009234, 9'h03D, 2'h1);
        op(9'h124, 20'h0000F, 32'h000000F0, 9'h138, 32'h000000FF, 9'h03D, 2'h1);
        op(9'h007, 20'h00000, 32'h00000000, 9'h13F, 32'h00000000, 9'h13F, 2'h2);
        op(9'h021, 20'h00000, 32'h00001234, 9'h005, 32'h00000000, 9'h005, 2'h2);
        acc(1'h0, 8'h00, 32'h0, 1'h0);
        // second reset in mid-run
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        acc(1'h0, 8'h0C, 32'h0, 1'h0);
        acc(1'h0, 8'h08, 32'h0, 1'h0);
        end_of_test();
    end
endmodule
